// file: rtl/srch_regs.svh
// Task-file offsets, field positions, reset values and counts
`ifndef SRCH_REGS_SVH
`define SRCH_REGS_SVH
`define SRCH_OFS_DATA      3'h0
`define SRCH_OFS_ERROR     3'h1
`define SRCH_OFS_COUNT     3'h2
`define SRCH_OFS_SECTOR    3'h3
`define SRCH_OFS_CYL_LO    3'h4
`define SRCH_OFS_CYL_HI    3'h5
`define SRCH_OFS_UNIT_HEAD 3'h6
`define SRCH_OFS_OPCODE    3'h7
`define SRCH_ERR_UNC_BIT   6
`define SRCH_ERR_IDNF_BIT  4
`define SRCH_ERR_ABT_BIT   2
`define SRCH_ERR_MASK      8'h54
`define SRCH_STS_BSY_BIT   7
`define SRCH_STS_RDY_BIT   6
`define SRCH_STS_DF_BIT    5
`define SRCH_STS_DSC_BIT   4
`define SRCH_STS_DRQ_BIT   3
`define SRCH_STS_COR_BIT   2
`define SRCH_STS_ERR_BIT   0
`define SRCH_DH_LBA_BIT    6
`define SRCH_OP_READ       8'h20
`define SRCH_OP_READ_EXT   8'h24
`define SRCH_CLASSIC_ZERO  17'h00100
`define SRCH_EXT_ZERO      17'h10000
`define SRCH_LAST_WORD     8'hFF
`define SRCH_SECT_PER_TRK  8'h3F
`define SRCH_LAST_HEAD     4'hF
`define SRCH_RESET_BYTE    8'h00
`endif

// file: rtl/srch_pkg.sv
// Types shared by the sector read command handler
package srch_pkg;
    typedef enum logic [0:0] {
        SRCH_IDLE = 1'b0,
        SRCH_READ = 1'b1
    } srch_state_t;
endpackage

// file: rtl/srch_word_buffer.sv
// Small FIFO between the media word stream and the host data register
`timescale 1ns/1ps
`default_nettype none
module srch_word_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,       // System clock
    input  wire logic             resetn,    // Async reset, active low
    input  wire logic             flush,     // Drop all held words
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Space available
    input  wire logic [WIDTH-1:0] in_data,   // Word in
    output logic                  out_valid, // Word held
    input  wire logic             out_ready, // Word taken
    output logic      [WIDTH-1:0] out_data   // Oldest word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Pointers wrap naturally, so DEPTH must be a power of two
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    always_comb begin
        wr_d  = wr_q + AW'(push);
        rd_d  = rd_q + AW'(pop);
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

// file: rtl/srch_top.sv
// Sector read command handler behind the task-file registers
`timescale 1ns/1ps
`default_nettype none
`include "srch_regs.svh"
module srch_top
    import srch_pkg::*;
(
    input  wire logic        clk,              // 10 MHz system clock
    input  wire logic        resetn,           // Async reset, active low
    input  wire logic        tf_wr,            // Task-file write strobe
    input  wire logic        tf_rd,            // Task-file read strobe
    input  wire logic [2:0]  tf_addr,          // Task-file register select
    input  wire logic [7:0]  tf_wdata,         // Write byte
    output logic      [15:0] tf_rdata,         // Read data, one cycle later
    input  wire logic        high_byte_select, // Read previous bytes
    output logic             med_req,          // Start one sector fetch
    output logic      [47:0] med_addr,         // Sector address to fetch
    output logic             med_chs,          // Address is geometry form
    input  wire logic        med_valid,        // Media word valid
    output logic             med_ready,        // Buffer can take word
    input  wire logic [15:0] med_word,         // Media word
    input  wire logic        med_unc,          // Uncorrectable sector
    input  wire logic        med_idnf          // Sector identifier missing
);
    srch_state_t state_q, state_d;
    logic [7:0]  sc_q, sc_d, scp_q, scp_d, sn_q, sn_d, snp_q, snp_d;
    logic [7:0]  cl_q, cl_d, clp_q, clp_d, ch_q, ch_d, chp_q, chp_d;
    logic [7:0]  dh_q, dh_d, err_q, err_d, wcnt_q, wcnt_d;
    logic [16:0] rem_q, rem_d;
    logic [47:0] addr_q, addr_d;
    logic        ext_q, ext_d, req_q, req_d;
    logic [15:0] rdata_q, rdata_d;
    logic        buf_valid, pop, flush, finish;
    logic [15:0] buf_data;
    logic [7:0]  status;

    assign tf_rdata = rdata_q;
    assign med_req  = req_q;
    assign med_addr = addr_q;
    assign med_chs  = !ext_q && !dh_q[`SRCH_DH_LBA_BIT];

    srch_word_buffer #(.WIDTH(16), .DEPTH(2)) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .flush     (flush),
        .in_valid  (med_valid && state_q == SRCH_READ),
        .in_ready  (med_ready),
        .in_data   (med_word),
        .out_valid (buf_valid),
        .out_ready (pop),
        .out_data  (buf_data)
    );

    // Geometry form packs sector in 7:0, cylinder in 23:8, head in 27:24
    function automatic logic [47:0] next_addr(input logic [47:0] a,
                                              input logic        chs);
        logic [47:0] n;
        n = a + 48'h1;
        if (chs) begin
            n = a;
            if (a[7:0] == `SRCH_SECT_PER_TRK) begin
                n[7:0] = 8'h01;
                if (a[27:24] == `SRCH_LAST_HEAD) begin
                    n[27:24] = 4'h0;
                    n[23:8]  = a[23:8] + 16'h0001;
                end else begin
                    n[27:24] = a[27:24] + 4'h1;
                end
            end else begin
                n[7:0] = a[7:0] + 8'h01;
            end
        end
        return n;
    endfunction

    always_comb begin
        status = `SRCH_RESET_BYTE;
        status[`SRCH_STS_BSY_BIT] = (state_q == SRCH_READ) && !buf_valid;
        status[`SRCH_STS_RDY_BIT] = 1'b1;
        status[`SRCH_STS_DSC_BIT] = 1'b1;
        status[`SRCH_STS_DRQ_BIT] = (state_q == SRCH_READ) && buf_valid;
        status[`SRCH_STS_ERR_BIT] = (err_q != 8'h00);
    end

    always_comb begin
        state_d = state_q;
        sc_d = sc_q;   scp_d = scp_q; sn_d = sn_q;   snp_d = snp_q;
        cl_d = cl_q;   clp_d = clp_q; ch_d = ch_q;   chp_d = chp_q;
        dh_d = dh_q;   err_d = err_q; wcnt_d = wcnt_q;
        rem_d = rem_q; addr_d = addr_q; ext_d = ext_q;
        rdata_d = rdata_q;
        req_d = 1'b0;
        pop = 1'b0;
        flush = 1'b0;
        finish = 1'b0;
        if (tf_rd) begin
            case (tf_addr)
                `SRCH_OFS_DATA: begin
                    rdata_d = 16'h0000;
                    if (state_q == SRCH_READ && buf_valid) begin
                        rdata_d = buf_data;
                        pop = 1'b1;
                    end
                end
                `SRCH_OFS_ERROR:     rdata_d = {8'h00, err_q};
                `SRCH_OFS_COUNT:     rdata_d = {8'h00,
                    high_byte_select ? scp_q : sc_q};
                `SRCH_OFS_SECTOR:    rdata_d = {8'h00,
                    high_byte_select ? snp_q : sn_q};
                `SRCH_OFS_CYL_LO:    rdata_d = {8'h00,
                    high_byte_select ? clp_q : cl_q};
                `SRCH_OFS_CYL_HI:    rdata_d = {8'h00,
                    high_byte_select ? chp_q : ch_q};
                `SRCH_OFS_UNIT_HEAD: rdata_d = {8'h00, dh_q};
                default:             rdata_d = {8'h00, status};
            endcase
        end
        if (pop) begin
            wcnt_d = wcnt_q + 8'h01;
            if (wcnt_q == `SRCH_LAST_WORD) begin
                rem_d = rem_q - 17'h00001;
                if (rem_q == 17'h00001) begin
                    finish = 1'b1;
                end else begin
                    addr_d = next_addr(addr_q, med_chs);
                    req_d  = 1'b1;
                end
            end
        end
        if (state_q == SRCH_READ && (med_unc || med_idnf)) begin
            // Failing sector stays counted and addressed
            err_d = 8'h00;
            err_d[`SRCH_ERR_UNC_BIT]  = med_unc;
            err_d[`SRCH_ERR_IDNF_BIT] = med_idnf && !med_unc;
            rem_d  = rem_q;
            addr_d = addr_q;
            req_d  = 1'b0;
            flush  = 1'b1;
            finish = 1'b1;
        end
        if (finish) begin
            state_d = SRCH_IDLE;
            sc_d = rem_d[7:0];
            sn_d = addr_d[7:0];   cl_d = addr_d[15:8];
            ch_d = addr_d[23:16];
            if (ext_q) begin
                scp_d = rem_d[15:8];
                snp_d = addr_d[31:24]; clp_d = addr_d[39:32];
                chp_d = addr_d[47:40];
            end else begin
                dh_d[3:0] = addr_d[27:24];
            end
        end
        // Task-file writes while a read runs are ignored
        if (tf_wr && state_q == SRCH_IDLE) begin
            case (tf_addr)
                `SRCH_OFS_COUNT:  begin scp_d = sc_q; sc_d = tf_wdata; end
                `SRCH_OFS_SECTOR: begin snp_d = sn_q; sn_d = tf_wdata; end
                `SRCH_OFS_CYL_LO: begin clp_d = cl_q; cl_d = tf_wdata; end
                `SRCH_OFS_CYL_HI: begin chp_d = ch_q; ch_d = tf_wdata; end
                `SRCH_OFS_UNIT_HEAD: dh_d = tf_wdata;
                `SRCH_OFS_OPCODE: begin
                    err_d  = 8'h00;
                    wcnt_d = 8'h00;
                    if (tf_wdata[7:1] == `SRCH_OP_READ >> 1) begin
                        state_d = SRCH_READ;
                        req_d   = 1'b1;
                        ext_d   = 1'b0;
                        rem_d   = (sc_q == 8'h00) ? `SRCH_CLASSIC_ZERO
                                                  : {9'h000, sc_q};
                        addr_d  = {20'h00000, dh_q[3:0], ch_q, cl_q,
                                   sn_q};
                    end else if (tf_wdata == `SRCH_OP_READ_EXT) begin
                        state_d = SRCH_READ;
                        req_d   = 1'b1;
                        ext_d   = 1'b1;
                        rem_d   = ({scp_q, sc_q} == 16'h0000)
                                ? `SRCH_EXT_ZERO
                                : {1'b0, scp_q, sc_q};
                        addr_d  = {chp_q, clp_q, snp_q,
                                   ch_q, cl_q, sn_q};
                    end else begin
                        err_d[`SRCH_ERR_ABT_BIT] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SRCH_IDLE;
            sc_q <= `SRCH_RESET_BYTE;  scp_q <= `SRCH_RESET_BYTE;
            sn_q <= `SRCH_RESET_BYTE;  snp_q <= `SRCH_RESET_BYTE;
            cl_q <= `SRCH_RESET_BYTE;  clp_q <= `SRCH_RESET_BYTE;
            ch_q <= `SRCH_RESET_BYTE;  chp_q <= `SRCH_RESET_BYTE;
            dh_q <= `SRCH_RESET_BYTE;  err_q <= `SRCH_RESET_BYTE;
            wcnt_q <= 8'h00;
            rem_q <= 17'h00000;
            addr_q <= 48'h0;
            ext_q <= 1'b0;
            req_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            sc_q <= sc_d;  scp_q <= scp_d; sn_q <= sn_d;  snp_q <= snp_d;
            cl_q <= cl_d;  clp_q <= clp_d; ch_q <= ch_d;  chp_q <= chp_d;
            dh_q <= dh_d;  err_q <= err_d;
            wcnt_q <= wcnt_d;
            rem_q <= rem_d;
            addr_q <= addr_d;
            ext_q <= ext_d;
            req_q <= req_d;
            rdata_q <= rdata_d;
        end
    end

    sequence s_op_write(logic [7:0] op);
        tf_wr && tf_addr == `SRCH_OFS_OPCODE && tf_wdata == op
            && state_q == SRCH_IDLE;
    endsequence
    sequence s_last_pop;
        pop && wcnt_q == `SRCH_LAST_WORD && rem_q == 17'h00001
            && !med_unc && !med_idnf;
    endsequence

    chk_read_start: assert property (@(posedge clk) disable iff (!resetn)
        s_op_write(8'h20) |=> req_q && state_q == SRCH_READ)
        else $error("read opcode did not start fetch");
    chk_retry_ignored: assert property (@(posedge clk) disable iff (!resetn)
        s_op_write(8'h21) |=> req_q && !ext_q && err_q == 8'h00)
        else $error("retry opcode behaved differently");
    chk_zero_count: assert property (@(posedge clk) disable iff (!resetn)
        s_op_write(8'h20) ##0 sc_q == 8'h00 |=> rem_q == 17'h00100)
        else $error("zero count not 256");
    chk_ext_zero: assert property (@(posedge clk) disable iff (!resetn)
        s_op_write(8'h24) ##0 (sc_q == 8'h00 && scp_q == 8'h00)
            |=> rem_q == 17'h10000 && ext_q)
        else $error("zero ext count not 65536");
    chk_err_bits: assert property (@(posedge clk) disable iff (!resetn)
        (err_q & ~`SRCH_ERR_MASK) == 8'h00)
        else $error("illegal error bit set");
    chk_stop_error: assert property (@(posedge clk) disable iff (!resetn)
        state_q == SRCH_READ && med_unc
            |=> state_q == SRCH_IDLE && !req_q && !buf_valid
                && err_q[`SRCH_ERR_UNC_BIT] ##1 !req_q [*3])
        else $error("read continued past failing sector");
    chk_end_status: assert property (@(posedge clk) disable iff (!resetn)
        $fell(state_q == SRCH_READ) |-> !status[`SRCH_STS_BSY_BIT]
            && !status[`SRCH_STS_DF_BIT] && !status[`SRCH_STS_COR_BIT])
        else $error("bad status at command end");
    chk_clean_end: assert property (@(posedge clk) disable iff (!resetn)
        s_last_pop |=> err_q == 8'h00 && sc_q == 8'h00
            && !status[`SRCH_STS_ERR_BIT] && sn_q == $past(addr_q[7:0]))
        else $error("clean completion left error or count");
    chk_word_out: assert property (@(posedge clk) disable iff (!resetn)
        tf_rd && tf_addr == `SRCH_OFS_DATA && status[`SRCH_STS_DRQ_BIT]
            |=> tf_rdata == $past(buf_data))
        else $error("data word not returned");
    chk_bad_op: assert property (@(posedge clk) disable iff (!resetn)
        s_op_write(8'h99) |=> err_q == 8'h04 && state_q == SRCH_IDLE)
        else $error("unknown opcode not aborted");
endmodule
`default_nettype wire

// file: dv/srch_media_model.sv
// Media-side model: 256 words per sector fetch, optional stall and fault
`timescale 1ns/1ps
`default_nettype none
module srch_media_model (
    input  wire logic        clk,       // System clock
    input  wire logic        resetn,    // Async reset, active low
    input  wire logic        med_req,   // Sector fetch start
    input  wire logic [47:0] med_addr,  // Sector to fetch
    input  wire logic        med_ready, // Design can take a word
    output logic             med_valid, // Word offered
    output logic      [15:0] med_word,  // Address byte, word index
    output logic             med_unc,   // Uncorrectable sector pulse
    output logic             med_idnf,  // Missing sector pulse
    input  wire logic        slow,      // Offer words every other cycle
    input  wire logic [1:0]  fault,     // 1 uncorrectable, 2 missing
    input  wire logic [7:0]  fault_sec  // Low address byte that faults
);
    logic [8:0] left_q;
    logic [7:0] sec_q;
    logic       tick_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            med_valid <= 1'b0;
            med_unc   <= 1'b0;
            med_idnf  <= 1'b0;
            tick_q    <= 1'b0;
            left_q    <= 9'h000;
            sec_q     <= 8'h00;
            med_word  <= 16'hFFFF;
        end else begin
            med_unc  <= 1'b0;
            med_idnf <= 1'b0;
            tick_q   <= ~tick_q;
            if (med_req && fault != 2'h0 && med_addr[7:0] == fault_sec) begin
                med_unc  <= fault[0];
                med_idnf <= fault[1];
            end else if (med_req) begin
                left_q <= 9'h100;
                sec_q  <= med_addr[7:0];
            end else if (med_valid && med_ready) begin
                // Released word lines flip so a stale copy never matches
                med_valid <= 1'b0;
                med_word  <= ~med_word;
                left_q    <= left_q - 9'h001;
            end else if (!med_valid && left_q != 9'h000 &&
                         (!slow || tick_q)) begin
                med_valid <= 1'b1;
                med_word  <= {sec_q, 8'(9'h100 - left_q)};
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/srch_top_tb.sv
// Self-checking bench for the sector read command handler
`timescale 1ns/1ps
`default_nettype none
module srch_top_tb;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        tf_wr = 1'b0;
    logic        tf_rd = 1'b0;
    logic [2:0]  tf_addr = 3'h0;
    logic [7:0]  tf_wdata = 8'h00;
    logic [15:0] tf_rdata;
    logic        high_byte_select = 1'b0;
    logic        med_req, med_chs, med_valid, med_ready, med_unc, med_idnf;
    logic [47:0] med_addr;
    logic [15:0] med_word;
    logic        slow = 1'b0;
    logic [1:0]  fault = 2'h0;
    logic [7:0]  fault_sec = 8'h00;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cycles = 0;

    srch_top i_srch_top (.clk(clk), .resetn(resetn), .tf_wr(tf_wr),
        .tf_rd(tf_rd), .tf_addr(tf_addr), .tf_wdata(tf_wdata),
        .tf_rdata(tf_rdata), .high_byte_select(high_byte_select),
        .med_req(med_req), .med_addr(med_addr), .med_chs(med_chs),
        .med_valid(med_valid), .med_ready(med_ready), .med_word(med_word),
        .med_unc(med_unc), .med_idnf(med_idnf));
    srch_media_model i_srch_media_model (.clk(clk), .resetn(resetn),
        .med_req(med_req), .med_addr(med_addr), .med_ready(med_ready),
        .med_valid(med_valid), .med_word(med_word), .med_unc(med_unc),
        .med_idnf(med_idnf), .slow(slow), .fault(fault),
        .fault_sec(fault_sec));

    always #50 clk = ~clk;
    // Whole run needs about 14k cycles; near three times that means a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done;
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        tf_wr = 1'b1;
        tf_addr = a;
        tf_wdata = d;
        @(negedge clk);
        tf_wr = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(negedge clk);
        tf_rd = 1'b1;
        tf_addr = a;
        @(negedge clk);
        tf_rd = 1'b0;
        @(negedge clk);
        d = tf_rdata;
    endtask
    task automatic expect_reg(input logic [2:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        check(d, e);
    endtask
    // Polls status bit b until it equals v; bounded so a stuck flag fails
    task automatic wait_status(input int b, input logic v);
        logic [15:0] d;
        int tries;
        tries = 0;
        do begin
            rd(3'h7, d);
            tries++;
        end while (d[b] !== v && tries < 40);
        check(16'(d[b]), 16'(v));
    endtask
    task automatic read_sectors(input logic [7:0] sec, input int n);
        logic [15:0] d;
        for (int s = 0; s < n; s++) begin
            for (int i = 0; i < 256; i++) begin
                wait_status(3, 1'b1);
                rd(3'h0, d);
                check(d, {sec + 8'(s), 8'(i)});
            end
        end
    endtask

    task automatic t_abort;
        wr(3'h6, 8'h00);
        check(16'(med_chs), 16'h0001);
        wr(3'h7, 8'h99);
        expect_reg(3'h1, 16'h0004);
        expect_reg(3'h7, 16'h0051);
    endtask
    task automatic t_classic(input logic [7:0] op, input logic sl);
        slow = sl;
        fault = 2'h0;
        wr(3'h6, 8'h42);
        wr(3'h2, 8'h02);
        wr(3'h3, 8'hFE);
        wr(3'h4, 8'h34);
        wr(3'h5, 8'h12);
        wr(3'h7, op);
        check(16'(med_chs), 16'h0000);
        read_sectors(8'hFE, 2);
        wait_status(7, 1'b0);
        expect_reg(3'h2, 16'h0000);
        expect_reg(3'h3, 16'h00FF);
        expect_reg(3'h4, 16'h0034);
        expect_reg(3'h6, 16'h0042);
        expect_reg(3'h1, 16'h0000);
        expect_reg(3'h7, 16'h0050);
    endtask
    // Geometry form: last sector of a track rolls to sector 1, next head
    task automatic t_geometry;
        slow = 1'b0;
        fault = 2'h0;
        wr(3'h6, 8'h05);
        wr(3'h2, 8'h02);
        wr(3'h3, 8'h3F);
        wr(3'h4, 8'h34);
        wr(3'h5, 8'h12);
        wr(3'h7, 8'h20);
        check(16'(med_chs), 16'h0001);
        read_sectors(8'h3F, 1);
        read_sectors(8'h01, 1);
        wait_status(7, 1'b0);
        expect_reg(3'h2, 16'h0000);
        expect_reg(3'h3, 16'h0001);
        expect_reg(3'h4, 16'h0034);
        expect_reg(3'h5, 16'h0012);
        expect_reg(3'h6, 16'h0006);
    endtask
    task automatic t_ext_unc;
        slow = 1'b1;
        fault = 2'h1;
        fault_sec = 8'hFF;
        wr(3'h2, 8'h00);
        wr(3'h2, 8'h02);
        wr(3'h3, 8'hC3);
        wr(3'h3, 8'hFE);
        wr(3'h4, 8'hB2);
        wr(3'h4, 8'hE5);
        wr(3'h5, 8'hA1);
        wr(3'h5, 8'hD4);
        wr(3'h6, 8'h40);
        wr(3'h7, 8'h24);
        read_sectors(8'hFE, 1);
        wait_status(7, 1'b0);
        expect_reg(3'h1, 16'h0040);
        expect_reg(3'h7, 16'h0051);
        expect_reg(3'h0, 16'h0000);
        expect_reg(3'h2, 16'h0001);
        expect_reg(3'h3, 16'h00FF);
        expect_reg(3'h4, 16'h00E5);
        expect_reg(3'h5, 16'h00D4);
        high_byte_select = 1'b1;
        expect_reg(3'h2, 16'h0000);
        expect_reg(3'h3, 16'h00C3);
        expect_reg(3'h4, 16'h00B2);
        expect_reg(3'h5, 16'h00A1);
        high_byte_select = 1'b0;
    endtask
    task automatic t_zero_count(input logic ext);
        slow = 1'b0;
        fault = 2'h2;
        fault_sec = 8'h01;
        wr(3'h2, 8'h00);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h6, 8'h40);
        wr(3'h7, ext ? 8'h24 : 8'h20);
        read_sectors(8'h00, 1);
        wait_status(7, 1'b0);
        expect_reg(3'h1, 16'h0010);
        expect_reg(3'h2, 16'h00FF);
        expect_reg(3'h3, 16'h0001);
        high_byte_select = ext;
        if (ext) begin
            expect_reg(3'h2, 16'h00FF);
        end
        high_byte_select = 1'b0;
    endtask

    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        t_abort();
        t_classic(8'h21, 1'b1);
        t_classic(8'h20, 1'b0);
        t_geometry();
        t_ext_unc();
        t_zero_count(1'b0);
        t_zero_count(1'b1);
        test_done();
    end
endmodule
`default_nettype wire
